// *** common/serial_status_cfg.svh ***
// Register offsets, field positions, reset values and counts of the
// serial port status and interrupt block.
// Assumes byte addresses on a 32-bit Avalon-MM register bus.
`ifndef SERIAL_STATUS_CFG_SVH
`define SERIAL_STATUS_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_COMMAND 8'h00
`define OFS_IRQ_ENABLE_SET 8'h08
`define OFS_IRQ_DISABLE 8'h0C
`define OFS_IRQ_MASK 8'h10
`define OFS_CHANNEL_STATUS 8'h14

// ----------------------------------------------------------------
// Channel status field positions
// ----------------------------------------------------------------
`define BIT_SLAVE_NO_RESP 29
`define BIT_CHECKSUM 28
`define BIT_ID_PARITY 27
`define BIT_SYNC_FIELD 26
`define BIT_BUS_BIT 25
`define BIT_CTS_LEVEL 23
`define BIT_CTS_CHANGE 19
`define BIT_XFER_DONE 15
`define BIT_ID_SEEN 14
`define BIT_NO_ACK 13
`define BIT_RX_BUF_FULL 12

// ----------------------------------------------------------------
// Command register field positions
// ----------------------------------------------------------------
`define BIT_CMD_CLR_STATUS 8
`define BIT_CMD_CLR_NOACK 14

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define RST_IRQ_MASK 32'h0000_0000
`define RST_STATUS 32'h0000_0000
`define IRQ_BITS 32'h3E08_F000
`define READ_ZERO 32'h0000_0000

// ----------------------------------------------------------------
// Cycle counts
// ----------------------------------------------------------------
`define SYNC_STAGES 2

`endif

// *** common/serial_status_pkg.sv ***
// Types shared by the serial port status and interrupt block.
// Assumes compilation before every design file.
package serial_status_pkg;

  typedef logic [31:0] word_t;

  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } bus_state_t;

endpackage

// *** rtl/cts_sync.sv ***
// Two-flop synchroniser and change detector for the clear-to-send pin.
// Assumes an asynchronous pin and a free-running clk.
module cts_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cts_pin,
  output logic cts_level,
  output logic cts_change
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  logic last_q;
  logic last_d;
  logic change_q;
  logic change_d;

  // ----------------------------------------------------------------
  // Synchroniser; the first stage feeds only the second
  // ----------------------------------------------------------------
  always_comb begin
    meta_d = cts_pin;
    sync_d = meta_q;
    last_d = sync_q;
    change_d = sync_q ^ last_q;
  end

  // Reset to low, so a pin already high at release gives one change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
      change_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
      change_q <= change_d;
    end
  end

  assign cts_level = sync_q;
  assign cts_change = change_q;

endmodule // cts_sync

// *** rtl/serial_port_status_irq.sv ***
// Status flags, interrupt mask and interrupt request of a serial port
// with LIN support, reached over an Avalon-MM slave with waitrequest.
// Assumes event inputs are one-cycle pulses from logic on clk and
// that cts_pin is asynchronous.
//
// Operation
// - Enable-set write of one sets mask bit
// - Enable-set write of zero changes nothing
// - Slave-no-response flag bit 29, sticky
// - Checksum error flag bit 28, sticky
// - Identifier parity flag bit 27, sticky
// - Sync field flag bit 26, slave only
// - Bit error flag bit 25, sticky
// - Bit 23 shows clear-to-send level
// - Bit 19 set on change, cleared by read
// - Bit 15 set once transfer completes
// - Bit 14 set once identifier sent/received
// - No-ack bit 13 held until no-ack clear
// - Bit 12 mirrors DMA buffer-full signal
`include "serial_status_cfg.svh"

module serial_port_status_irq #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  input wire logic cts_pin,
  input wire logic lin_slave_mode,
  input wire logic slave_no_response_evt,
  input wire logic checksum_evt,
  input wire logic id_parity_evt,
  input wire logic sync_field_evt,
  input wire logic bus_bit_evt,
  input wire logic transfer_done_evt,
  input wire logic identifier_evt,
  input wire logic no_ack_evt,
  input wire logic dma_buffer_full
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 5 || ADDR_W > 8) begin : g_addr_check
    $error("ADDR_W must lie between 5 and 8");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic serial_status_pkg::word_t lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (8'(a) == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  serial_status_pkg::bus_state_t state_q;
  serial_status_pkg::bus_state_t state_d;
  logic wait_q;
  logic wait_d;
  serial_status_pkg::word_t rdata_q;
  serial_status_pkg::word_t rdata_d;
  serial_status_pkg::word_t mask_q;
  serial_status_pkg::word_t mask_d;
  logic irq_q;
  logic irq_d;

  logic slave_no_response_err_q;
  logic slave_no_response_err_d;
  logic checksum_err_q;
  logic checksum_err_d;
  logic id_parity_err_q;
  logic id_parity_err_d;
  logic sync_field_err_q;
  logic sync_field_err_d;
  logic bus_bit_err_q;
  logic bus_bit_err_d;
  logic handshake_change_flag_q;
  logic handshake_change_flag_d;
  logic transfer_complete_flag_q;
  logic transfer_complete_flag_d;
  logic identifier_seen_flag_q;
  logic identifier_seen_flag_d;
  logic no_ack_flag_q;
  logic no_ack_flag_d;
  logic rx_buffer_full_flag_q;
  logic rx_buffer_full_flag_d;

  logic cts_level;
  logic cts_change;
  logic acc_done;
  logic wr_done;
  logic rd_status_done;
  serial_status_pkg::word_t wdata_be;
  logic clear_status_cmd;
  logic clear_noack_cmd;
  logic set_mask_wr;
  logic clr_mask_wr;
  serial_status_pkg::word_t status_word;

  // ----------------------------------------------------------------
  // Clear-to-send input
  // ----------------------------------------------------------------
  cts_sync u_cts_sync (
    .clk(clk),
    .rst_n(rst_n),
    .cts_pin(cts_pin),
    .cts_level(cts_level),
    .cts_change(cts_change)
  );

  // ----------------------------------------------------------------
  // Bus slave: one wait cycle, access completes in BUS_ACK
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    wait_d = 1'b1;
    rdata_d = rdata_q;
    unique case (state_q)
      serial_status_pkg::BUS_IDLE: begin
        if (read || write) begin
          state_d = serial_status_pkg::BUS_ACK;
          wait_d = 1'b0;
          rdata_d = `READ_ZERO;
          if (read && hit(address, `OFS_CHANNEL_STATUS)) begin
            rdata_d = status_word;
          end else if (read && hit(address, `OFS_IRQ_MASK)) begin
            rdata_d = mask_q;
          end
        end
      end
      serial_status_pkg::BUS_ACK: begin
        state_d = serial_status_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= serial_status_pkg::BUS_IDLE;
      wait_q <= 1'b1;
      rdata_q <= `READ_ZERO;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  assign acc_done = (state_q == serial_status_pkg::BUS_ACK);
  assign wr_done = acc_done && write;
  assign rd_status_done = acc_done && read && hit(address, `OFS_CHANNEL_STATUS);
  assign wdata_be = writedata & lane_mask(byteenable);
  assign clear_status_cmd = wr_done && hit(address, `OFS_COMMAND)
                            && wdata_be[`BIT_CMD_CLR_STATUS];
  assign clear_noack_cmd = wr_done && hit(address, `OFS_COMMAND)
                           && wdata_be[`BIT_CMD_CLR_NOACK];
  assign set_mask_wr = wr_done && hit(address, `OFS_IRQ_ENABLE_SET);
  assign clr_mask_wr = wr_done && hit(address, `OFS_IRQ_DISABLE);

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  always_comb begin
    status_word = `RST_STATUS;
    status_word[`BIT_SLAVE_NO_RESP] = slave_no_response_err_q;
    status_word[`BIT_CHECKSUM] = checksum_err_q;
    status_word[`BIT_ID_PARITY] = id_parity_err_q;
    status_word[`BIT_SYNC_FIELD] = sync_field_err_q;
    status_word[`BIT_BUS_BIT] = bus_bit_err_q;
    status_word[`BIT_CTS_LEVEL] = cts_level;
    status_word[`BIT_CTS_CHANGE] = handshake_change_flag_q;
    status_word[`BIT_XFER_DONE] = transfer_complete_flag_q;
    status_word[`BIT_ID_SEEN] = identifier_seen_flag_q;
    status_word[`BIT_NO_ACK] = no_ack_flag_q;
    status_word[`BIT_RX_BUF_FULL] = rx_buffer_full_flag_q;
  end

  // ----------------------------------------------------------------
  // Flags; an event in the clearing cycle wins
  // ----------------------------------------------------------------
  always_comb begin
    slave_no_response_err_d = slave_no_response_evt
                              || (slave_no_response_err_q && !clear_status_cmd);
    checksum_err_d = checksum_evt || (checksum_err_q && !clear_status_cmd);
    id_parity_err_d = id_parity_evt || (id_parity_err_q && !clear_status_cmd);
    sync_field_err_d = (sync_field_evt && lin_slave_mode)
                       || (sync_field_err_q && !clear_status_cmd);
    bus_bit_err_d = bus_bit_evt || (bus_bit_err_q && !clear_status_cmd);
    // Only a change already returned by the read is cleared
    handshake_change_flag_d = cts_change
                              || (handshake_change_flag_q
                                  && !(rd_status_done && rdata_q[`BIT_CTS_CHANGE]));
    transfer_complete_flag_d = transfer_done_evt
                               || (transfer_complete_flag_q && !clear_status_cmd);
    identifier_seen_flag_d = identifier_evt
                             || (identifier_seen_flag_q && !clear_status_cmd);
    no_ack_flag_d = no_ack_evt || (no_ack_flag_q && !clear_noack_cmd);
    rx_buffer_full_flag_d = dma_buffer_full;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slave_no_response_err_q <= 1'b0;
      checksum_err_q <= 1'b0;
      id_parity_err_q <= 1'b0;
      sync_field_err_q <= 1'b0;
      bus_bit_err_q <= 1'b0;
      handshake_change_flag_q <= 1'b0;
      transfer_complete_flag_q <= 1'b0;
      identifier_seen_flag_q <= 1'b0;
      no_ack_flag_q <= 1'b0;
      rx_buffer_full_flag_q <= 1'b0;
    end else begin
      slave_no_response_err_q <= slave_no_response_err_d;
      checksum_err_q <= checksum_err_d;
      id_parity_err_q <= id_parity_err_d;
      sync_field_err_q <= sync_field_err_d;
      bus_bit_err_q <= bus_bit_err_d;
      handshake_change_flag_q <= handshake_change_flag_d;
      transfer_complete_flag_q <= transfer_complete_flag_d;
      identifier_seen_flag_q <= identifier_seen_flag_d;
      no_ack_flag_q <= no_ack_flag_d;
      rx_buffer_full_flag_q <= rx_buffer_full_flag_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt mask and request
  // ----------------------------------------------------------------
  always_comb begin
    mask_d = mask_q;
    if (set_mask_wr) begin
      mask_d = mask_q | (wdata_be & `IRQ_BITS);
    end else if (clr_mask_wr) begin
      mask_d = mask_q & ~(wdata_be & `IRQ_BITS);
    end
    irq_d = |(status_word & mask_q);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= `RST_IRQ_MASK;
      irq_q <= 1'b0;
    end else begin
      mask_q <= mask_d;
      irq_q <= irq_d;
    end
  end

  assign readdata = rdata_q;
  assign waitrequest = wait_q;
  assign irq = irq_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence set_write_s;
    acc_done && write && hit(address, `OFS_IRQ_ENABLE_SET);
  endsequence

  sequence status_clear_s;
    acc_done && write && hit(address, `OFS_COMMAND) && wdata_be[`BIT_CMD_CLR_STATUS];
  endsequence

  property sticky_p(logic ev, logic fl);
    @(posedge clk) disable iff (!rst_n)
      (ev |=> fl) and ((fl && !clear_status_cmd) |=> fl);
  endproperty

  mask_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    set_write_s |=> (mask_q == ($past(mask_q) | ($past(wdata_be) & `IRQ_BITS))))
    else $error("enable write did not set mask bits");

  mask_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(acc_done && write) |=> $stable(mask_q))
    else $error("mask changed without a write");

  no_resp_flag_a: assert property (sticky_p(slave_no_response_evt,
    slave_no_response_err_q)) else $error("slave-no-response flag wrong");

  checksum_flag_a: assert property (sticky_p(checksum_evt, checksum_err_q))
    else $error("checksum flag wrong");

  parity_flag_a: assert property (sticky_p(id_parity_evt, id_parity_err_q))
    else $error("identifier parity flag wrong");

  sync_master_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!lin_slave_mode && !sync_field_err_q) |=> !sync_field_err_q)
    else $error("sync field flag set outside slave mode");

  bit_flag_a: assert property (sticky_p(bus_bit_evt, bus_bit_err_q))
    else $error("bit error flag wrong");

  cts_image_a: assert property (@(posedge clk) disable iff (!rst_n)
    cts_pin [*3] |-> status_word[`BIT_CTS_LEVEL])
    else $error("status does not show clear-to-send level");

  cts_change_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cts_level != $past(cts_level)) |-> ##2 handshake_change_flag_q)
    else $error("handshake change not flagged");

  done_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    status_clear_s ##0 !transfer_done_evt |=> !transfer_complete_flag_q)
    else $error("transfer complete flag not cleared");

  id_seen_a: assert property (sticky_p(identifier_evt, identifier_seen_flag_q))
    else $error("identifier flag wrong");

  noack_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (no_ack_flag_q && !clear_noack_cmd) |=> no_ack_flag_q)
    else $error("no-ack flag dropped early");

  buf_mirror_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 (rx_buffer_full_flag_q == $past(dma_buffer_full)))
    else $error("buffer full bit does not follow input");

  irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((status_word & mask_q) != `RST_STATUS) |=> irq)
    else $error("interrupt not raised");

endmodule // serial_port_status_irq

// *** tb/lin_node_model.sv ***
// Behavioural remote LIN node: protocol event pulses, clear-to-send pin
// and DMA buffer-full level. Assumes its tasks are called from clk domain.
module lin_node_model (
  input wire logic clk,
  output logic [7:0] evt,
  output logic cts_pin,
  output logic dma_buffer_full
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    evt = 8'h00;
    cts_pin = 1'b0;
    dma_buffer_full = 1'b0;
  end

  // One-cycle pulse, as the event inputs accept
  task automatic pulse(input int i);
    @(posedge clk);
    evt <= 8'h01 << i;
    @(posedge clk);
    evt <= 8'h00;
  endtask

  task automatic set_cts(input logic v);
    @(posedge clk);
    cts_pin <= v;
  endtask

  task automatic set_dma(input logic v);
    @(posedge clk);
    dma_buffer_full <= v;
  endtask
endmodule // lin_node_model

// *** tb/serial_port_status_irq_tb_top.sv ***
// Self-checking bench of the serial port status and interrupt block.
// Assumes the design's Avalon-MM slave answers with waitrequest.
module serial_port_status_irq_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, rst_n, read, write, lin_slave_mode, waitrequest, irq;
  logic cts_pin, dma_buffer_full;
  logic [7:0] address, evt;
  logic [3:0] byteenable, lanes;
  logic [31:0] writedata, readdata;
  int miscompares, n_compared, cycles;
  localparam int evt_pos[8] = '{29, 28, 27, 26, 25, 15, 14, 13};

  // ----------------------------------------------------------------
  // Design and far side
  // ----------------------------------------------------------------
  serial_port_status_irq dut (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .cts_pin(cts_pin),
    .lin_slave_mode(lin_slave_mode), .slave_no_response_evt(evt[0]),
    .checksum_evt(evt[1]), .id_parity_evt(evt[2]), .sync_field_evt(evt[3]),
    .bus_bit_evt(evt[4]), .transfer_done_evt(evt[5]), .identifier_evt(evt[6]),
    .no_ack_evt(evt[7]), .dma_buffer_full(dma_buffer_full)
  );

  lin_node_model node (
    .clk(clk), .evt(evt), .cts_pin(cts_pin), .dma_buffer_full(dma_buffer_full)
  );

  // ----------------------------------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Under two hundred cycles are needed; well above that means a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic chk_bit(input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // ----------------------------------------------------------------
  // Avalon-MM master
  // ----------------------------------------------------------------
  task automatic bus_acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] q);
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= lanes;
    write <= w;
    read <= !w;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_acc(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus_acc(1'b0, a, 32'h0000_0000, q);
    chk_word(exp, q);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd_chk(8'h14, 32'h0000_0000);
    rd_chk(8'h10, 32'h0000_0000);
    rd_chk(8'h04, 32'h0000_0000);
    chk_bit(1'b0, irq);
  endtask

  task automatic t_mask();
    wr(8'h08, 32'h0000_1000);
    rd_chk(8'h10, 32'h0000_1000);
    wr(8'h08, 32'h0000_0000);
    rd_chk(8'h10, 32'h0000_1000);
    wr(8'h10, 32'hFFFF_FFFF);
    rd_chk(8'h10, 32'h0000_1000);
    wr(8'h08, 32'h3E08_E000);
    rd_chk(8'h10, 32'h3E08_F000);
  endtask

  task automatic t_sticky();
    logic [31:0] exp;
    exp = 32'h0000_0000;
    @(posedge clk);
    lin_slave_mode <= 1'b0;
    node.pulse(3);
    rd_chk(8'h14, exp);
    @(posedge clk);
    lin_slave_mode <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      node.pulse(i);
      exp[evt_pos[i]] = 1'b1;
      rd_chk(8'h14, exp);
    end
    chk_bit(1'b1, irq);
    wr(8'h00, 32'h0000_0100);
    repeat (3) @(posedge clk);
    chk_bit(1'b0, irq);
    rd_chk(8'h14, 32'h0000_0000);
  endtask

  task automatic t_noack();
    node.pulse(7);
    rd_chk(8'h14, 32'h0000_2000);
    wr(8'h00, 32'h0000_0100);
    rd_chk(8'h14, 32'h0000_2000);
    wr(8'h00, 32'h0000_4000);
    rd_chk(8'h14, 32'h0000_0000);
  endtask

  task automatic t_cts();
    node.set_cts(1'b1);
    repeat (5) @(posedge clk);
    rd_chk(8'h14, 32'h0088_0000);
    rd_chk(8'h14, 32'h0080_0000);
    node.set_cts(1'b0);
    repeat (5) @(posedge clk);
    rd_chk(8'h14, 32'h0008_0000);
    chk_bit(1'b1, irq);
    rd_chk(8'h14, 32'h0000_0000);
  endtask

  task automatic t_dma();
    node.set_dma(1'b1);
    repeat (3) @(posedge clk);
    rd_chk(8'h14, 32'h0000_1000);
    chk_bit(1'b1, irq);
    wr(8'h0C, 32'h0000_1000);
    repeat (3) @(posedge clk);
    chk_bit(1'b0, irq);
    rd_chk(8'h10, 32'h3E08_E000);
    node.set_dma(1'b0);
    repeat (3) @(posedge clk);
    rd_chk(8'h14, 32'h0000_0000);
  endtask

  // Byte lanes gate which mask bits a set or clear write touches
  task automatic t_lanes();
    lanes = 4'h8;
    wr(8'h0C, 32'hFFFF_FFFF);
    rd_chk(8'h10, 32'h0008_E000);
    lanes = 4'h1;
    wr(8'h08, 32'hFFFF_FFFF);
    rd_chk(8'h10, 32'h0008_E000);
    lanes = 4'h2;
    wr(8'h08, 32'hFFFF_FFFF);
    lanes = 4'hF;
    rd_chk(8'h10, 32'h0008_F000);
  endtask

  initial begin
    rst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0000_0000;
    byteenable = 4'hF;
    lanes = 4'hF;
    lin_slave_mode = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_mask();
    t_sticky();
    t_noack();
    t_cts();
    t_dma();
    t_lanes();
    give_verdict();
  end
endmodule // serial_port_status_irq_tb_top
